// >>> load_decode_defines.vh
// Purpose: Constants for the load-linked and upper-immediate decode/execute block
// Assumes: 32-bit instruction words, 32-bit GPRs, 64-bit FPRs
// Notes: Field positions, opcodes and exception codes as `define macros
//
// Notes on behaviour
// - User halfword load: base plus sign-extended 9-bit offset, zero-extended 16-bit result.
// - User halfword load decodes as major 011000, subgroup 0110, minor 001.
// - Halfword loads with address bit 0 set raise address error, no access.
// - User loads translate with user mapping; request carries a user-mapping flag.
// - User load variants are reserved instructions unless the enhanced-addressing field is one.
// - User load variants raise coprocessor unusable unless system coprocessor access enabled.
// - Load-linked decodes as major 011000, subgroup 0011, 12-bit signed offset.
// - Load-linked writes the loaded word then sets the link flag.
// - Only one active sequence; each new load-linked replaces the old one.
// - Load-linked never signals other processors; no outgoing invalidate.
// - Both load-linked forms raise address error when either low address bit is set.
// - User load-linked decodes as major 011000, subgroup 0110, minor 110.
// - User load-linked starts a sequence finished later by the user conditional store.
// - User load-linked is the normal load-linked with user-mode translation.
// - User load-linked can report reserved instruction and coprocessor unusable too.
// - Upper immediate decodes as major 010000, bits 25..21 01101; no exceptions.
// - Upper immediate writes immediate shifted left 16 with zero low half.
// - Indexed FP load decodes as major 010101, bits 10..9 00, minor 101001000.
// - Indexed FP load: base plus index, low three bits ignored, 64-bit, no alignment error.
// - Indexed FP load is defined only with a 64-bit FPU in the wide register mode.
// - Indexed FP load reports only unusable, reserved, refill, invalid and watch.
// - Word load decodes as major 111111, 16-bit offset, aligned 32-bit word.
// - Word load raises address error when either low address bit is set.
`ifndef LOAD_DECODE_DEFINES_VH
`define LOAD_DECODE_DEFINES_VH

// ----------------------------------------------------------------
// Opcodes and sub-fields
// ----------------------------------------------------------------
`define OP_MAJOR_GROUP_C 6'h18
`define OP_MAJOR_GROUP_I 6'h10
`define OP_MAJOR_GROUP_F 6'h15
`define OP_WORD_LOAD 6'h3F
`define SUB_USER_SPACE_LOAD 4'h6
`define SUB_LINKED_LOAD 4'h3
`define MINOR_HALF_UNSIGNED_USER 3'h1
`define MINOR_LINKED_USER 3'h6
`define FIELD_UPPER_IMMEDIATE 5'h0D
`define FP_PAD_ZERO 2'h0
`define MINOR_FP_DOUBLE_INDEXED 9'h148

// ----------------------------------------------------------------
// Access sizes and exception codes
// ----------------------------------------------------------------
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
`define SIZE_DOUBLE 2'h3
`define EXC_NONE 3'h0
`define EXC_ADDRESS 3'h1
`define EXC_RESERVED 3'h2
`define EXC_COP_UNUSABLE 3'h3
`define EXC_TLB_REFILL 3'h4
`define EXC_TLB_INVALID 3'h5
`define EXC_WATCH 3'h6
`define EXC_BUS 3'h7

`endif

// >>> load_linked_and_upper_decode.v
// Purpose: Decode and execute a group of compressed-ISA loads
// Assumes: One instruction at a time; memory side answers with a done pulse
// Notes: The conditional-store logic reads and clears the link flag
`timescale 1ns/1ps
`include "load_decode_defines.vh"

module load_linked_and_upper_decode #(
   parameter DATA_W = 32,
   parameter PADDR_W = 32
) (
   input wire I_CLK,
   input wire I_RST_N,
   input wire I_ISSUE_VALID,
   input wire [31:0] I_INSTR,
   input wire [DATA_W-1:0] I_GPR_BASE,
   input wire [DATA_W-1:0] I_GPR_INDEX,
   input wire I_ENHANCED_VIRTUAL_ADDRESSING,
   input wire I_COP0_ACCESS_ENABLED,
   input wire I_COP1_USABLE,
   input wire I_FPU_64BIT,
   input wire I_FP_REGISTER_WIDTH_MODE,
   input wire I_CORE_BIG_ENDIAN_FLAG,
   input wire I_REVERSE_ENDIAN_FLAG,
   input wire I_LINK_CLEAR,
   input wire I_MEM_READY,
   input wire I_MEM_DONE,
   input wire [2:0] I_MEM_EXC,
   input wire [PADDR_W-1:0] I_MEM_PADDR,
   input wire [63:0] I_MEM_RDATA,
   output wire O_ISSUE_READY,
   output reg O_MEM_REQ,
   output reg [DATA_W-1:0] O_MEM_VADDR,
   output reg [1:0] O_MEM_SIZE,
   output reg O_MEM_USER_MAP,
   output reg O_MEM_PADDR_VALID,
   output reg [PADDR_W-1:0] O_MEM_PADDR_ADJ,
   output reg O_GPR_WE,
   output reg O_FPR_WE,
   output reg [4:0] O_WB_REG,
   output reg [63:0] O_WB_DATA,
   output reg O_WB_UNPREDICTABLE,
   output reg O_EXC_VALID,
   output reg [2:0] O_EXC_CODE,
   output reg O_LINK_FLAG
);

   // ----------------------------------------------------------------
   // States and local kinds
   // ----------------------------------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_REQ = 2'h1;
   localparam ST_WAIT = 2'h2;
   localparam K_NONE = 3'h0;
   localparam K_HALF_USER = 3'h1;
   localparam K_LINKED = 3'h2;
   localparam K_LINKED_USER = 3'h3;
   localparam K_UPPER = 3'h4;
   localparam K_FP_INDEXED = 3'h5;
   localparam K_WORD = 3'h6;

   // ----------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------
   wire [5:0] major = I_INSTR[31:26];
   wire [4:0] rt = I_INSTR[25:21];
   wire [3:0] subgroup = I_INSTR[15:12];
   wire [2:0] minor = I_INSTR[11:9];
   wire [4:0] fd = I_INSTR[15:11];

   reg [2:0] kind;
   always @* begin
      kind = K_NONE;
      case (major)
         `OP_MAJOR_GROUP_C: begin
            if (subgroup == `SUB_LINKED_LOAD)
               kind = K_LINKED;
            else if (subgroup == `SUB_USER_SPACE_LOAD &&
                     minor == `MINOR_HALF_UNSIGNED_USER)
               kind = K_HALF_USER;
            else if (subgroup == `SUB_USER_SPACE_LOAD && minor == `MINOR_LINKED_USER)
               kind = K_LINKED_USER;
         end
         `OP_MAJOR_GROUP_I: begin
            if (rt == `FIELD_UPPER_IMMEDIATE)
               kind = K_UPPER;
         end
         `OP_MAJOR_GROUP_F: begin
            if (I_INSTR[10:9] == `FP_PAD_ZERO && I_INSTR[8:0] == `MINOR_FP_DOUBLE_INDEXED)
               kind = K_FP_INDEXED;
         end
         `OP_WORD_LOAD: kind = K_WORD;
         default: kind = K_NONE;
      endcase
   end

   // ----------------------------------------------------------------
   // Effective address
   // ----------------------------------------------------------------
   wire [DATA_W-1:0] off9 = {{(DATA_W-9){I_INSTR[8]}}, I_INSTR[8:0]};
   wire [DATA_W-1:0] off12 = {{(DATA_W-12){I_INSTR[11]}}, I_INSTR[11:0]};
   wire [DATA_W-1:0] off16 = {{(DATA_W-16){I_INSTR[15]}}, I_INSTR[15:0]};
   reg [DATA_W-1:0] eff;
   always @* begin
      case (kind)
         K_HALF_USER, K_LINKED_USER: eff = I_GPR_BASE + off9;
         K_LINKED: eff = I_GPR_BASE + off12;
         K_FP_INDEXED: eff = (I_GPR_BASE + I_GPR_INDEX) & ~{{(DATA_W-3){1'b0}}, 3'h7};
         default: eff = I_GPR_BASE + off16;
      endcase
   end

   // ----------------------------------------------------------------
   // Issue-time exceptions, in priority order
   // ----------------------------------------------------------------
   wire user_kind = (kind == K_HALF_USER) || (kind == K_LINKED_USER);
   reg [2:0] issue_exc;
   always @* begin
      issue_exc = `EXC_NONE;
      if (kind == K_NONE)
         issue_exc = `EXC_RESERVED;
      else if (user_kind && !I_ENHANCED_VIRTUAL_ADDRESSING)
         issue_exc = `EXC_RESERVED;
      else if (user_kind && !I_COP0_ACCESS_ENABLED)
         issue_exc = `EXC_COP_UNUSABLE;
      else if (kind == K_FP_INDEXED && !I_COP1_USABLE)
         issue_exc = `EXC_COP_UNUSABLE;
      else if (kind == K_HALF_USER && eff[0])
         issue_exc = `EXC_ADDRESS;
      else if ((kind == K_LINKED || kind == K_LINKED_USER) && eff[1:0] != 2'h0)
         issue_exc = `EXC_ADDRESS;
      else if (kind == K_WORD && eff[1:0] != 2'h0)
         issue_exc = `EXC_ADDRESS;
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   reg [1:0] state;
   reg [2:0] cur_kind;
   reg [4:0] cur_reg;
   reg cur_lane;
   assign O_ISSUE_READY = (state == ST_IDLE);
   wire take = I_ISSUE_VALID && O_ISSUE_READY;

   // Memory exceptions filtered per kind; the FP load cannot report bus or address errors
   wire [2:0] mem_exc_f = (cur_kind == K_FP_INDEXED &&
      (I_MEM_EXC == `EXC_ADDRESS || I_MEM_EXC == `EXC_BUS)) ? `EXC_NONE : I_MEM_EXC;

   // Halfword lane: bit 1 of the virtual address xor core endianness
   wire [15:0] half = cur_lane ? I_MEM_RDATA[31:16] : I_MEM_RDATA[15:0];

   always @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state <= ST_IDLE;
         cur_kind <= K_NONE;
         cur_reg <= 5'h00;
         cur_lane <= 1'b0;
         O_MEM_REQ <= 1'b0;
         O_MEM_VADDR <= {DATA_W{1'b0}};
         O_MEM_SIZE <= 2'h0;
         O_MEM_USER_MAP <= 1'b0;
         O_MEM_PADDR_VALID <= 1'b0;
         O_MEM_PADDR_ADJ <= {PADDR_W{1'b0}};
         O_GPR_WE <= 1'b0;
         O_FPR_WE <= 1'b0;
         O_WB_REG <= 5'h00;
         O_WB_DATA <= 64'h0000000000000000;
         O_WB_UNPREDICTABLE <= 1'b0;
         O_EXC_VALID <= 1'b0;
         O_EXC_CODE <= `EXC_NONE;
         O_LINK_FLAG <= 1'b0;
      end else begin
         O_GPR_WE <= 1'b0;
         O_FPR_WE <= 1'b0;
         O_EXC_VALID <= 1'b0;
         O_MEM_PADDR_VALID <= 1'b0;
         // Clear from conditional store; a link set in the same cycle wins below
         if (I_LINK_CLEAR)
            O_LINK_FLAG <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (take) begin
                  cur_kind <= kind;
                  cur_reg <= (kind == K_FP_INDEXED) ? fd : rt;
                  cur_lane <= eff[1] ^ I_CORE_BIG_ENDIAN_FLAG;
                  if (issue_exc != `EXC_NONE) begin
                     O_EXC_VALID <= 1'b1;
                     O_EXC_CODE <= issue_exc;
                  end else if (kind == K_UPPER) begin
                     O_GPR_WE <= 1'b1;
                     O_WB_REG <= I_INSTR[20:16];
                     O_WB_DATA <= {32'h00000000, I_INSTR[15:0], 16'h0000};
                     O_WB_UNPREDICTABLE <= 1'b0;
                  end else begin
                     O_MEM_REQ <= 1'b1;
                     O_MEM_VADDR <= eff;
                     O_MEM_SIZE <= (kind == K_HALF_USER) ? `SIZE_HALF :
                        (kind == K_FP_INDEXED) ? `SIZE_DOUBLE : `SIZE_WORD;
                     O_MEM_USER_MAP <= user_kind;
                     state <= ST_REQ;
                  end
               end
            end
            ST_REQ: begin
               if (I_MEM_READY) begin
                  O_MEM_REQ <= 1'b0;
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (I_MEM_DONE) begin
                  state <= ST_IDLE;
                  // Reverse-endian flips physical bit 1 of a halfword access
                  O_MEM_PADDR_VALID <= 1'b1;
                  O_MEM_PADDR_ADJ <= (cur_kind == K_HALF_USER) ?
                     (I_MEM_PADDR ^ {{(PADDR_W-2){1'b0}}, I_REVERSE_ENDIAN_FLAG, 1'b0}) :
                     I_MEM_PADDR;
                  if (mem_exc_f != `EXC_NONE) begin
                     O_EXC_VALID <= 1'b1;
                     O_EXC_CODE <= mem_exc_f;
                  end else begin
                     O_WB_REG <= cur_reg;
                     O_WB_UNPREDICTABLE <= 1'b0;
                     case (cur_kind)
                        K_HALF_USER: begin
                           O_GPR_WE <= 1'b1;
                           O_WB_DATA <= {48'h000000000000, half};
                        end
                        K_LINKED, K_LINKED_USER: begin
                           O_GPR_WE <= 1'b1;
                           O_WB_DATA <= {32'h00000000, I_MEM_RDATA[31:0]};
                           // Single flag: a new linked load simply replaces any old sequence.
                           // No coherence signal leaves here, so others are not disturbed.
                           O_LINK_FLAG <= 1'b1;
                        end
                        K_FP_INDEXED: begin
                           O_FPR_WE <= 1'b1;
                           O_WB_DATA <= I_MEM_RDATA;
                           O_WB_UNPREDICTABLE <= !(I_FPU_64BIT && I_FP_REGISTER_WIDTH_MODE);
                        end
                        default: begin
                           O_GPR_WE <= 1'b1;
                           O_WB_DATA <= {{32{I_MEM_RDATA[31]}}, I_MEM_RDATA[31:0]};
                        end
                     endcase
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

endmodule // load_linked_and_upper_decode

// >>> load_decode_properties.sv
// Purpose: Port-level assertions for the load decode block
// Assumes: One clock, asynchronous active-low reset
// Notes: Sees a subset of the top ports only, bound at the foot
`timescale 1ns/1ps
module load_decode_properties #(parameter DATA_W = 32, parameter PADDR_W = 32) (
   input wire I_CLK, input wire I_RST_N, input wire I_ISSUE_VALID, input wire [31:0] I_INSTR,
   input wire I_ENHANCED_VIRTUAL_ADDRESSING, input wire I_COP0_ACCESS_ENABLED,
   input wire I_REVERSE_ENDIAN_FLAG, input wire I_LINK_CLEAR, input wire I_MEM_DONE,
   input wire [PADDR_W-1:0] I_MEM_PADDR, input wire O_ISSUE_READY, input wire O_MEM_REQ,
   input wire [DATA_W-1:0] O_MEM_VADDR, input wire [1:0] O_MEM_SIZE, input wire O_MEM_PADDR_VALID,
   input wire [PADDR_W-1:0] O_MEM_PADDR_ADJ, input wire O_GPR_WE, input wire [63:0] O_WB_DATA,
   input wire O_EXC_VALID, input wire [2:0] O_EXC_CODE, input wire O_LINK_FLAG
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   wire take = I_ISSUE_VALID && O_ISSUE_READY;
   wire usr = I_INSTR[31:26] == 6'h18 && I_INSTR[15:12] == 4'h6 &&
              (I_INSTR[11:9] == 3'h1 || I_INSTR[11:9] == 3'h6);
   upper_imm_a: assert property (take && I_INSTR[31:21] == 11'h20D |=> O_GPR_WE && !O_EXC_VALID
      && O_WB_DATA[31:0] == {$past(I_INSTR[15:0]), 16'h0000}) else $error("upper immediate wrong");
   no_eva_a: assert property (take && usr && !I_ENHANCED_VIRTUAL_ADDRESSING |=>
      O_EXC_VALID && O_EXC_CODE == 3'h2) else $error("user load not refused");
   cop0_off_a: assert property (take && usr && I_ENHANCED_VIRTUAL_ADDRESSING &&
      !I_COP0_ACCESS_ENABLED |=> O_EXC_VALID && O_EXC_CODE == 3'h3) else $error("no unusable");
   half_align_a: assert property (O_MEM_REQ && O_MEM_SIZE == 2'h1 |-> !O_MEM_VADDR[0])
      else $error("odd halfword access");
   word_align_a: assert property (O_MEM_REQ && O_MEM_SIZE == 2'h2 |-> O_MEM_VADDR[1:0] == 2'h0)
      else $error("unaligned word access");
   fp_low_a: assert property (O_MEM_REQ && O_MEM_SIZE == 2'h3 |-> O_MEM_VADDR[2:0] == 3'h0)
      else $error("doubleword low bits kept");
   link_set_a: assert property ($rose(O_LINK_FLAG) |-> O_GPR_WE && $past(I_MEM_DONE))
      else $error("link flag set without load");
   link_clear_a: assert property (I_LINK_CLEAR && !I_MEM_DONE |=> !O_LINK_FLAG)
      else $error("link flag not cleared");
   link_hold_a: assert property (O_LINK_FLAG && !I_LINK_CLEAR |=> O_LINK_FLAG)
      else $error("link flag lost");
   lane_flip_a: assert property (O_MEM_PADDR_VALID && O_MEM_SIZE == 2'h1 |-> O_MEM_PADDR_ADJ[1] ==
      ($past(I_MEM_PADDR[1]) ^ $past(I_REVERSE_ENDIAN_FLAG))) else $error("lane bit wrong");
endmodule // load_decode_properties

bind load_linked_and_upper_decode load_decode_properties #(.DATA_W(DATA_W), .PADDR_W(PADDR_W)) i_p (
   .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_ISSUE_VALID(I_ISSUE_VALID), .I_INSTR(I_INSTR),
   .I_ENHANCED_VIRTUAL_ADDRESSING(I_ENHANCED_VIRTUAL_ADDRESSING),
   .I_COP0_ACCESS_ENABLED(I_COP0_ACCESS_ENABLED), .I_REVERSE_ENDIAN_FLAG(I_REVERSE_ENDIAN_FLAG),
   .I_LINK_CLEAR(I_LINK_CLEAR), .I_MEM_DONE(I_MEM_DONE), .I_MEM_PADDR(I_MEM_PADDR),
   .O_ISSUE_READY(O_ISSUE_READY), .O_MEM_REQ(O_MEM_REQ), .O_MEM_VADDR(O_MEM_VADDR),
   .O_MEM_SIZE(O_MEM_SIZE), .O_MEM_PADDR_VALID(O_MEM_PADDR_VALID), .O_MEM_PADDR_ADJ(O_MEM_PADDR_ADJ),
   .O_GPR_WE(O_GPR_WE), .O_WB_DATA(O_WB_DATA), .O_EXC_VALID(O_EXC_VALID),
   .O_EXC_CODE(O_EXC_CODE), .O_LINK_FLAG(O_LINK_FLAG));

// >>> mem_side_model.sv
// Purpose: Translation and memory side seen by the load decode block
// Assumes: One request at a time, latency set by the bench
// Notes: Answer lines show inverted values while no answer stands
`timescale 1ns/1ps
module mem_side_model (
   input wire i_clk, input wire i_rst_n, input wire i_req, input wire [31:0] i_vaddr,
   input wire [1:0] i_lat, input wire [2:0] i_exc, output reg o_ready, output reg o_done,
   output reg [2:0] o_exc, output reg [31:0] o_paddr, output reg [63:0] o_rdata
);
   reg [31:0] va;
   initial begin o_ready = 1'b0; o_done = 1'b0; o_exc = 3'h0; o_paddr = 32'h0; o_rdata = 64'h0; end
   // ----------------------------------------------------------------
   // Accept, then answer; done never shares the ready cycle
   // ----------------------------------------------------------------
   always begin
      @(posedge i_clk);
      if (i_rst_n && i_req) begin
         va = i_vaddr;
         repeat (i_lat) @(posedge i_clk);
         #2 o_ready = 1'b1;
         @(posedge i_clk);
         #2 o_ready = 1'b0;
         if (i_lat != 2'h0) begin repeat (i_lat) @(posedge i_clk); #2; end
         o_done = 1'b1;
         o_exc = i_exc;
         o_paddr = va ^ 32'h8000_0002;
         o_rdata = {~va, va ^ 32'h5A5A_0F0F};
         @(posedge i_clk);
         #2 o_done = 1'b0;
         o_exc = ~o_exc;
         o_paddr = ~o_paddr;
         o_rdata = ~o_rdata;
      end
   end
endmodule // mem_side_model

// >>> test_load_linked_and_upper_decode.sv
// Purpose: Self-checking bench for the load decode block
// Assumes: Memory side modelled by mem_side_model
// Notes: Reference recomputes each result from the instruction word
`timescale 1ns/1ps
module test_load_linked_and_upper_decode;
   reg clk = 1'b0, rst_n = 1'b0, vld = 1'b0, clr = 1'b0, e_mem, e_fp, e_full, e_usr, e_unp, got;
   reg e_lnk = 1'b0;
   reg [31:0] ins = 32'h0, base = 32'h0, idx = 32'h0, e_va, e_pa;
   reg [6:0] fl = 7'h0; // eva cop0 cop1 fpu64 fr big rev
   reg [1:0] lat = 2'h0, e_sz;
   reg [2:0] mx = 3'h0, e_code;
   reg [4:0] e_reg;
   reg [63:0] e_dat, rd;
   wire rdy, req, mrdy, mdone, umap, gwe, fwe, unp, exv, lnk, pv;
   wire [31:0] va, mpa, padj;
   wire [1:0] sz;
   wire [2:0] mexc, ecode;
   wire [4:0] wreg;
   wire [63:0] wdat, mrd;
   integer error_cnt = 0, n_checks = 0, seed = 18446, i, k;
   always #25 clk = ~clk;
   load_linked_and_upper_decode i_load_linked_and_upper_decode (.I_CLK(clk), .I_RST_N(rst_n),
      .I_ISSUE_VALID(vld), .I_INSTR(ins), .I_GPR_BASE(base), .I_GPR_INDEX(idx),
      .I_ENHANCED_VIRTUAL_ADDRESSING(fl[6]), .I_COP0_ACCESS_ENABLED(fl[5]), .I_COP1_USABLE(fl[4]),
      .I_FPU_64BIT(fl[3]), .I_FP_REGISTER_WIDTH_MODE(fl[2]), .I_CORE_BIG_ENDIAN_FLAG(fl[1]),
      .I_REVERSE_ENDIAN_FLAG(fl[0]), .I_LINK_CLEAR(clr), .I_MEM_READY(mrdy), .I_MEM_DONE(mdone),
      .I_MEM_EXC(mexc), .I_MEM_PADDR(mpa), .I_MEM_RDATA(mrd), .O_ISSUE_READY(rdy), .O_MEM_REQ(req),
      .O_MEM_VADDR(va), .O_MEM_SIZE(sz), .O_MEM_USER_MAP(umap), .O_MEM_PADDR_VALID(pv),
      .O_MEM_PADDR_ADJ(padj), .O_GPR_WE(gwe), .O_FPR_WE(fwe), .O_WB_REG(wreg), .O_WB_DATA(wdat),
      .O_WB_UNPREDICTABLE(unp), .O_EXC_VALID(exv), .O_EXC_CODE(ecode), .O_LINK_FLAG(lnk));
   mem_side_model i_mem_side_model (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_vaddr(va),
      .i_lat(lat), .i_exc(mx), .o_ready(mrdy), .o_done(mdone), .o_exc(mexc), .o_paddr(mpa),
      .o_rdata(mrd));
   task chk(input [63:0] g, input [63:0] e);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask
   task tally_and_finish;
      begin
         if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // ----------------------------------------------------------------
   // Reference model
   // ----------------------------------------------------------------
   task ref_model;
      reg [31:0] ea;
      begin
         e_mem = 0; e_fp = 0; e_full = 1; e_usr = 0; e_unp = 0; e_code = 0; e_sz = 0; ea = 0;
         e_reg = ins[25:21];
         if (ins[31:21] == 11'h20D) begin
            e_reg = ins[20:16]; e_full = 0; e_dat = {32'h0, ins[15:0], 16'h0};
         end else if (ins[31:26] == 6'h18 && ins[15:12] == 4'h3) begin
            e_mem = 1; e_sz = 2; ea = base + {{20{ins[11]}}, ins[11:0]};
         end else if (ins[31:26] == 6'h18 && ins[15:12] == 4'h6) begin
            e_mem = 1; e_usr = 1; e_sz = ins[9] ? 2'h1 : 2'h2; ea = base + {{23{ins[8]}}, ins[8:0]};
            if (!fl[6]) e_code = 2; else if (!fl[5]) e_code = 3;
         end else if (ins[31:26] == 6'h15 && ins[10:0] == 11'h148) begin
            e_mem = 1; e_fp = 1; e_sz = 3; e_reg = ins[15:11]; ea = (base + idx) & ~32'h7;
            e_unp = !(fl[3] && fl[2]); if (!fl[4]) e_code = 3;
         end else if (ins[31:26] == 6'h3F) begin
            e_mem = 1; e_sz = 2; ea = base + {{16{ins[15]}}, ins[15:0]};
         end else e_code = 2;
         if (e_code == 0 && ((e_sz == 1 && ea[0]) || (e_sz == 2 && ea[1:0] != 0))) e_code = 1;
         if (e_code != 0) e_mem = 0;
         e_va = ea; rd = {~ea, ea ^ 32'h5A5A_0F0F};
         // Reverse-endian flips physical bit 1 of halfword accesses only
         e_pa = (ea ^ 32'h8000_0002) ^ ((e_sz == 1 && fl[0]) ? 32'h2 : 32'h0);
         // The FP indexed load never reports address or bus errors
         if (e_mem && mx != 0 && !(e_fp && (mx == 1 || mx == 7))) e_code = mx;
         else if (e_sz == 1) e_dat = {48'h0, (ea[1] ^ fl[1]) ? rd[31:16] : rd[15:0]};
         else if (e_fp) e_dat = rd;
         else if (ins[31:26] == 6'h3F) e_dat = {{32{rd[31]}}, rd[31:0]};
         else if (e_mem) begin e_dat = {32'h0, rd[31:0]}; e_lnk = 1; end
      end
   endtask
   task run;
      begin
         ref_model;
         @(posedge clk); #2 vld = 1;
         @(posedge clk); #2 vld = 0; got = 0;
         for (k = 0; k < 40 && !got; k = k + 1) begin
            if (k == 0) chk(req, e_mem);
            if (req) chk({umap, sz, va}, {e_usr, e_sz, e_va});
            if (gwe | fwe | exv) begin
               got = 1;
               chk({exv, fwe, gwe}, e_code != 0 ? 3'h4 : e_fp ? 3'h2 : 3'h1);
               if (e_mem) chk({pv, padj}, {1'b1, e_pa});
               if (e_code != 0) chk(ecode, e_code);
               else begin
                  chk(wreg, e_reg);
                  chk(e_full ? wdat : {32'h0, wdat[31:0]}, e_dat);
                  if (e_fp) chk(unp, e_unp);
               end
            end else begin @(posedge clk); #2; end
         end
         if (!got) begin
            error_cnt = error_cnt + 1;
            tally_and_finish;
         end else chk(lnk, e_lnk);
      end
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #2 rst_n = 1;
      for (i = 0; i < 180; i = i + 1) begin
         base = $random(seed); idx = $random(seed); ins = $random(seed);
         fl = (i % 4 == 0) ? 7'($random(seed)) : (7'($random(seed)) | 7'h7C);
         lat = 2'($random(seed)); mx = (i % 5 == 1) ? 3'(4 + i % 4) : 3'h0;
         case (i % 6)
            0: ins[31:21] = 11'h20D;
            1: ins = {6'h18, ins[25:16], 4'h3, ins[11:0]};
            2: ins = {6'h18, ins[25:16], 4'h6, 3'h1, ins[8:0]};
            3: ins = {6'h18, ins[25:16], 4'h6, 3'h6, ins[8:0]};
            4: ins = {6'h15, ins[25:11], 11'h148};
            default: ins[31:26] = (i % 12 == 5) ? 6'h3F : 6'h3A;
         endcase
         if ((i / 6) % 3 != 2) begin ins[1:0] = 2'h0; base[1:0] = 2'h0; end
         if (i % 7 == 3) begin
            @(posedge clk); #2 clr = 1;
            @(posedge clk); #2 clr = 0; e_lnk = 0;
            chk(lnk, 1'b0);
         end
         run;
      end
      tally_and_finish;
   end
endmodule // test_load_linked_and_upper_decode
